/* File: power_ctl_regs.svh */
`ifndef POWER_CTL_REGS_SVH
`define POWER_CTL_REGS_SVH

// ********************************
// Register map (byte addresses)
// ********************************
`define ADDR_LOW_BITS 8
`define STOP_LOW_ADDR 8'h00
`define MODE_CTRL_ADDR 8'h04
`define POWER_STAT_ADDR 8'h08

// ********************************
// Reset values
// ********************************
`define STOP_LOW_RESET 8'hFF
`define MODE_CTRL_RESET 1'h0

// ********************************
// Stop and mode register bit positions
// ********************************
`define STOP_HOST_BIT 0
`define STOP_TIMER_BIT 1
`define STOP_KEYBOARD_BIT 2
`define STOP_TWOWIRE_B_BIT 3
`define STOP_TWOWIRE_A_BIT 4
`define STOP_SERIAL_BIT 6
`define MODE_SSEL_BIT 0

// ********************************
// Peripheral unit indices
// ********************************
`define UNIT_COUNT 7
`define UNIT_HOST 0
`define UNIT_TIMER 1
`define UNIT_KEYBOARD 2
`define UNIT_TWOWIRE_B 3
`define UNIT_TWOWIRE_A 4
`define UNIT_SERIAL 5
`define UNIT_PWM 6

// Units that are reset, not retained, when halted
`define UNIT_RESET_TYPE 7'h60
`define UNIT_NONE 7'h00
`define UNIT_ALL 7'h7F

// ********************************
// Bus encodings
// ********************************
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

/* File: power_ctl_pkg.sv */
`include "power_ctl_regs.svh"

package power_ctl_pkg;

   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_EXEC = 3'b001,
      ST_SLEEP = 3'b010,
      ST_SW_STANDBY = 3'b011,
      ST_HW_STANDBY = 3'b100
   } power_state_type;

   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_STOP = 2'b01,
      SEL_MODE = 2'b10,
      SEL_STAT = 2'b11
   } reg_sel_type;

   typedef struct packed {
      logic [`UNIT_COUNT-1:0] clk_en;
      logic [`UNIT_COUNT-1:0] rst;
   } periph_ctrl_type;

endpackage

/* File: periph_gate.sv */
`include "power_ctl_regs.svh"

module periph_gate
   import power_ctl_pkg::*;
(
   input power_state_type state,
   input wire logic [`UNIT_COUNT-1:0] stop_units,
   output periph_ctrl_type ctrl
);

   // ********************************
   // Per-unit clock gate and reset
   // ********************************
   always_comb begin
      case (state)
         ST_EXEC, ST_SLEEP: begin
            // Unstopped units keep running
            ctrl.clk_en = ~stop_units;
            // Retained units just lose clock
            ctrl.rst = stop_units & `UNIT_RESET_TYPE;
         end
         ST_SW_STANDBY: begin
            ctrl.clk_en = `UNIT_NONE;
            // Only serial and pwm lose state
            ctrl.rst = `UNIT_RESET_TYPE;
         end
         default: begin
            // Reset and hardware standby clear all
            ctrl.clk_en = `UNIT_NONE;
            ctrl.rst = `UNIT_ALL;
         end
      endcase
   end

endmodule

/* File: power_mode_ctrl.sv */
`include "power_ctl_regs.svh"

// How it works
// - writing 1 to a stop bit stops its peripheral; 0 lets it run
// - bit6 serial, bits4/3 two-wire ports, bit1 timer pair
// - bit2 stops keyboard controller, its mask registers and pull-ups
// - bit0 stops host port and its wake-up mask register
// - sleep request moves executing state into a halted state
// - accepted interrupt returns sleep or software standby to executing
// - standby pin low forces hardware standby from every state
// - reset pin low enters reset from every state unless standby pin is low
// - retained halt keeps registers, suspends, resumes when clocked
// - reset halt initialises registers and state machine
// - in executing and sleep only units with stop bit set halt; others keep running
// - software standby retains all units except serial and pwm
module power_mode_ctrl
   import power_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic chip_reset_n,
   input wire logic hw_standby_n,
   input wire logic sleep_req,
   input wire logic irq_accept,
   output power_state_type power_state,
   output logic cpu_halt,
   output periph_ctrl_type periph_ctrl
);

   // ********************************
   // Helpers
   // ********************************
   function automatic reg_sel_type decode(input logic [31:0] addr);
      case (addr[`ADDR_LOW_BITS-1:0])
         `STOP_LOW_ADDR: decode = SEL_STOP;
         `MODE_CTRL_ADDR: decode = SEL_MODE;
         `POWER_STAT_ADDR: decode = SEL_STAT;
         default: decode = SEL_NONE;
      endcase
   endfunction

   function automatic logic [`UNIT_COUNT-1:0] stop_map(
      input logic [7:0] r);
      logic [`UNIT_COUNT-1:0] u;
      u = `UNIT_NONE;
      u[`UNIT_HOST] = r[`STOP_HOST_BIT];
      u[`UNIT_TIMER] = r[`STOP_TIMER_BIT];
      u[`UNIT_KEYBOARD] = r[`STOP_KEYBOARD_BIT];
      u[`UNIT_TWOWIRE_B] = r[`STOP_TWOWIRE_B_BIT];
      u[`UNIT_TWOWIRE_A] = r[`STOP_TWOWIRE_A_BIT];
      u[`UNIT_SERIAL] = r[`STOP_SERIAL_BIT];
      // Pwm stop bit lives in the high register, not here
      u[`UNIT_PWM] = 1'b0;
      return u;
   endfunction

   // ********************************
   // Pin synchronisers
   // ********************************
   logic res_meta_q;
   logic res_sync_q;
   logic hw_standby_n_meta_q;
   logic hw_standby_n_sync_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         res_meta_q <= 1'b0;
         res_sync_q <= 1'b0;
      end else begin
         res_meta_q <= chip_reset_n;
         res_sync_q <= res_meta_q;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hw_standby_n_meta_q <= 1'b1;
         hw_standby_n_sync_q <= 1'b1;
      end else begin
         hw_standby_n_meta_q <= hw_standby_n;
         hw_standby_n_sync_q <= hw_standby_n_meta_q;
      end
   end

   // ********************************
   // Bus slave
   // ********************************
   logic [7:0] stop_q;
   logic ssel_q;
   logic wr_pend_q;
   reg_sel_type wr_sel_q;
   logic [31:0] rdata_q;
   power_state_type state_q;
   power_state_type state_d;
   logic take;
   reg_sel_type sel;
   logic in_rst;
   logic wr_stop;
   logic wr_mode;
   logic [7:0] stop_view;
   logic mode_view;

   // Word accesses only; other sizes complete but do nothing
   assign take = hsel && htrans[1] && hready && hsize == `HSIZE_WORD;
   assign sel = haddr[1:0] == 2'b00 ? decode(haddr) : SEL_NONE;
   // Every access finishes with no wait state
   assign hreadyout = 1'b1;
   assign hresp = `HRESP_OKAY;
   assign hrdata = rdata_q;

   // Reset state and hardware standby clear the registers too
   assign in_rst = state_q == ST_RESET || state_q == ST_HW_STANDBY;
   assign wr_stop = wr_pend_q && wr_sel_q == SEL_STOP && !in_rst;
   assign wr_mode = wr_pend_q && wr_sel_q == SEL_MODE && !in_rst;

   // A read sees a write that lands at the same edge
   assign stop_view = in_rst ? `STOP_LOW_RESET
      : wr_stop ? hwdata[7:0] : stop_q;
   assign mode_view = in_rst ? `MODE_CTRL_RESET
      : wr_mode ? hwdata[`MODE_SSEL_BIT] : ssel_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         wr_sel_q <= SEL_NONE;
      end else if (hready) begin
         wr_pend_q <= take && hwrite;
         wr_sel_q <= sel;
      end
   end

   // Read data is fetched in the address phase; back to back is safe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         case (sel)
            SEL_STOP: rdata_q <= {24'h00_0000, stop_view};
            SEL_MODE: rdata_q <= {31'h0000_0000, mode_view};
            SEL_STAT: rdata_q <= {29'h0000_0000, state_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // All bits writable; keeping 7 and 5 set is up to software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stop_q <= `STOP_LOW_RESET;
      end else if (in_rst) begin
         stop_q <= `STOP_LOW_RESET;
      end else if (wr_stop) begin
         stop_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ssel_q <= `MODE_CTRL_RESET;
      end else if (in_rst) begin
         ssel_q <= `MODE_CTRL_RESET;
      end else if (wr_mode) begin
         ssel_q <= hwdata[`MODE_SSEL_BIT];
      end
   end

   // ********************************
   // Power state machine
   // ********************************
   always_comb begin
      state_d = state_q;
      if (!hw_standby_n_sync_q) begin
         state_d = ST_HW_STANDBY;
      end else if (!res_sync_q) begin
         state_d = ST_RESET;
      end else begin
         case (state_q)
            ST_RESET: state_d = ST_EXEC;
            ST_EXEC: begin
               if (sleep_req) begin
                  state_d = ssel_q ? ST_SW_STANDBY : ST_SLEEP;
               end
            end
            ST_SLEEP, ST_SW_STANDBY: begin
               if (irq_accept) begin
                  state_d = ST_EXEC;
               end
            end
            // Leaving hardware standby always passes through reset
            ST_HW_STANDBY: state_d = ST_RESET;
            default: state_d = ST_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign power_state = state_q;
   assign cpu_halt = state_q != ST_EXEC;

   // ********************************
   // Peripheral gating
   // ********************************
   periph_ctrl_type gate_d;
   periph_ctrl_type gate_q;

   periph_gate u_gate (
      .state(state_q),
      .stop_units(stop_map(stop_q)),
      .ctrl(gate_d)
   );

   // Registered so gate and reset lines are glitch free
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gate_q.clk_en <= `UNIT_NONE;
         gate_q.rst <= `UNIT_ALL;
      end else begin
         gate_q <= gate_d;
      end
   end

   assign periph_ctrl = gate_q;

   // ********************************
   // Checks
   // ********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic run;
   assign run = hw_standby_n_sync_q && res_sync_q;

   sequence s_sleep_irq;
      state_q == ST_SLEEP && run
      ##0 irq_accept;
   endsequence

   sequence s_swstby_irq;
      state_q == ST_SW_STANDBY && run
      ##0 irq_accept;
   endsequence

   property p_wake(s);
      s |=> state_q == ST_EXEC;
   endproperty

   a_sleep_entry: assert property (
      state_q == ST_EXEC && run && sleep_req
      |=> state_q == ($past(ssel_q) ? ST_SW_STANDBY : ST_SLEEP))
      else $error("sleep request did not halt");

   a_sleep_wake: assert property (p_wake(s_sleep_irq))
      else $error("interrupt did not leave sleep");

   a_swstby_wake: assert property (p_wake(s_swstby_irq))
      else $error("interrupt did not leave software standby");

   a_hw_standby_wins: assert property (
      !hw_standby_n_sync_q |=> state_q == ST_HW_STANDBY)
      else $error("standby pin did not force standby");

   a_reset_entry: assert property (
      hw_standby_n_sync_q && !res_sync_q |=> state_q == ST_RESET)
      else $error("reset pin did not enter reset");

   a_stop_write: assert property (
      wr_stop |=> stop_q == $past(hwdata[7:0]))
      else $error("stop register write lost");

   a_stop_reset: assert property (
      $fell(reset) |-> stop_q == `STOP_LOW_RESET)
      else $error("stop register reset value wrong");

   a_stop_pin_reset: assert property (
      (state_q == ST_RESET || state_q == ST_HW_STANDBY)
      |=> stop_q == `STOP_LOW_RESET)
      else $error("stop register kept through reset state");

   a_mode_pin_reset: assert property (
      (state_q == ST_RESET || state_q == ST_HW_STANDBY)
      |=> ssel_q == `MODE_CTRL_RESET)
      else $error("mode register kept through reset state");

   a_serial_gate: assert property (
      state_q == ST_EXEC && stop_q[`STOP_SERIAL_BIT]
      |=> !periph_ctrl.clk_en[`UNIT_SERIAL]
      && periph_ctrl.rst[`UNIT_SERIAL])
      else $error("serial port not halted with reset");

   a_keyboard_gate: assert property (
      state_q == ST_EXEC
      |=> periph_ctrl.clk_en[`UNIT_KEYBOARD]
      == !$past(stop_q[`STOP_KEYBOARD_BIT]))
      else $error("keyboard gate does not follow stop bit");

   a_host_gate: assert property (
      state_q == ST_EXEC && stop_q[`STOP_HOST_BIT]
      |=> !periph_ctrl.clk_en[`UNIT_HOST]
      && !periph_ctrl.rst[`UNIT_HOST])
      else $error("host port not halted with retention");

   a_retain_resume: assert property (
      state_q == ST_EXEC && stop_q[`STOP_TIMER_BIT]
      ##1 state_q == ST_EXEC && !stop_q[`STOP_TIMER_BIT]
      |=> periph_ctrl.clk_en[`UNIT_TIMER]
      && !periph_ctrl.rst[`UNIT_TIMER])
      else $error("timer did not resume after stop");

   a_hw_reset_all: assert property (
      state_q == ST_HW_STANDBY |=> periph_ctrl.rst == `UNIT_ALL)
      else $error("hardware standby did not reset units");

   a_others_run: assert property (
      (state_q == ST_EXEC || state_q == ST_SLEEP)
      |=> periph_ctrl.clk_en == ~stop_map($past(stop_q)))
      else $error("unstopped unit lost its clock");

   a_swstby_keep: assert property (
      state_q == ST_SW_STANDBY
      |=> periph_ctrl.rst == `UNIT_RESET_TYPE
      && periph_ctrl.clk_en == `UNIT_NONE)
      else $error("software standby reset wrong units");

endmodule

/* File: periph_model.sv */
`include "power_ctl_regs.svh"

// ********************************
// Peripheral stand-in: one activity counter per unit
// ********************************
module periph_model
   import power_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire periph_ctrl_type ctrl,
   output logic [`UNIT_COUNT-1:0][7:0] cnt_q
);
   timeunit 1ns;
   timeprecision 100ps;

   // Reset wins over clocking; no enable means the count is held
   always_ff @(posedge clk or posedge reset) begin
      for (int i = 0; i < `UNIT_COUNT; i++) begin
         if (reset || ctrl.rst[i]) begin
            cnt_q[i] <= 8'h00;
         end else if (ctrl.clk_en[i]) begin
            cnt_q[i] <= cnt_q[i] + 8'h01;
         end
      end
   end
endmodule

/* File: power_mode_and_module_stop_control_test.sv */
`include "power_ctl_regs.svh"

module power_mode_and_module_stop_control_test
   import power_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic sleep_req = 1'b0;
   logic irq_accept = 1'b0;
   logic chip_reset_n = 1'b1;
   logic hw_standby_n = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [31:0] hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic hreadyout;
   logic hresp;
   logic cpu_halt;
   logic [7:0] saved;
   power_state_type power_state;
   periph_ctrl_type periph_ctrl;
   logic [`UNIT_COUNT-1:0][7:0] cnt;
   int err_count = 0;
   int tests_run = 0;
   // Rows keep bits 7 and 5 set, as software must
   logic [7:0] stop_rows [8] = '{8'hA0, 8'hE0, 8'hB0, 8'hA8,
      8'hA4, 8'hA2, 8'hA1, 8'hFF};
   logic [6:0] en_rows [8] = '{7'h7F, 7'h5F, 7'h6F, 7'h77,
      7'h7B, 7'h7D, 7'h7E, 7'h40};

   always #12.5 clk = ~clk;

   power_mode_ctrl u_power_mode_ctrl (
      .clk(clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .chip_reset_n(chip_reset_n),
      .hw_standby_n(hw_standby_n),
      .sleep_req(sleep_req),
      .irq_accept(irq_accept),
      .power_state(power_state),
      .cpu_halt(cpu_halt),
      .periph_ctrl(periph_ctrl)
   );

   periph_model u_periph_model (
      .clk(clk),
      .reset(reset),
      .ctrl(periph_ctrl),
      .cnt_q(cnt)
   );

   // ********************************
   // Reporting
   // ********************************
   task automatic finish_test();
      $display("Checks %0d, errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_state(input power_state_type e);
      tests_run++;
      if (power_state !== e) begin
         err_count++;
         $display("Error at %0t: state %0d, expected %0d", $time,
            power_state, e);
      end
   endtask

   task automatic cmp_ctrl(input logic [6:0] en, input logic [6:0] rs);
      tests_run++;
      if (periph_ctrl !== {en, rs}) begin
         err_count++;
         $display("Error at %0t: gating %h, expected %h", $time,
            periph_ctrl, {en, rs});
      end
   endtask

   // ********************************
   // Drivers and bounded waits
   // ********************************
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         err_count++;
         $display("Error at %0t: bus hang", $time);
         finish_test();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      cmp_data({31'h0, hresp}, {31'h0, `HRESP_OKAY});
   endtask

   task automatic wait_state(input power_state_type e);
      int n;
      n = 0;
      while (power_state !== e && n < 16) begin
         @(posedge clk);
         n++;
      end
      cmp_state(e);
      if (power_state !== e) begin
         finish_test();
      end
   endtask

   task automatic wait_ctrl(input logic [6:0] en, input logic [6:0] rs);
      int n;
      n = 0;
      while (periph_ctrl !== {en, rs} && n < 16) begin
         @(posedge clk);
         n++;
      end
      cmp_ctrl(en, rs);
      if (periph_ctrl !== {en, rs}) begin
         finish_test();
      end
   endtask

   task automatic pulse(input logic s);
      @(posedge clk);
      if (s) begin
         sleep_req <= 1'b1;
      end else begin
         irq_accept <= 1'b1;
      end
      @(posedge clk);
      sleep_req <= 1'b0;
      irq_accept <= 1'b0;
   endtask

   task automatic pins(input logic rn, input logic sn);
      @(posedge clk);
      chip_reset_n <= rn;
      hw_standby_n <= sn;
   endtask

   // Runaway guard
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("Error at %0t: run limit reached", $time);
      finish_test();
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      wait_state(ST_EXEC);
      bus(1'b0, `STOP_LOW_ADDR, 32'h0);
      cmp_data(rd, 32'hFF);
      wait_ctrl(7'h40, 7'h20);
      bus(1'b0, `POWER_STAT_ADDR, 32'h0);
      cmp_data(rd, 32'h1);
      bus(1'b0, 8'h0C, 32'h0);
      cmp_data(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, `STOP_LOW_ADDR, {24'h0, stop_rows[i]});
         bus(1'b0, `STOP_LOW_ADDR, 32'h0);
         cmp_data(rd, {24'h0, stop_rows[i]});
         wait_ctrl(en_rows[i], ~en_rows[i] & 7'h60);
      end
      // Sleep keeps peripherals as the stop bits say
      bus(1'b1, `STOP_LOW_ADDR, 32'hE0);
      pulse(1'b1);
      wait_state(ST_SLEEP);
      cmp_data({31'h0, cpu_halt}, 32'h1);
      wait_ctrl(7'h5F, 7'h20);
      pulse(1'b0);
      wait_state(ST_EXEC);
      pulse(1'b0);
      @(posedge clk);
      cmp_state(ST_EXEC);
      // Software standby: timer retained, serial reset
      bus(1'b1, `MODE_CTRL_ADDR, 32'h1);
      bus(1'b0, `MODE_CTRL_ADDR, 32'h0);
      cmp_data(rd, 32'h1);
      pulse(1'b1);
      wait_state(ST_SW_STANDBY);
      wait_ctrl(7'h00, 7'h60);
      saved = cnt[`UNIT_TIMER];
      repeat (4) @(posedge clk);
      cmp_data({24'h0, cnt[`UNIT_TIMER]}, {24'h0, saved});
      cmp_data({24'h0, cnt[`UNIT_SERIAL]}, 32'h0);
      pulse(1'b0);
      wait_state(ST_EXEC);
      wait_ctrl(7'h5F, 7'h20);
      repeat (4) @(posedge clk);
      cmp_data({31'h0, cnt[`UNIT_TIMER] != saved}, 32'h1);
      // Pins: reset from a halted state, standby over reset
      pulse(1'b1);
      wait_state(ST_SW_STANDBY);
      pins(1'b0, 1'b1);
      wait_state(ST_RESET);
      wait_ctrl(7'h00, 7'h7F);
      pins(1'b0, 1'b0);
      wait_state(ST_HW_STANDBY);
      pins(1'b1, 1'b1);
      wait_state(ST_EXEC);
      pins(1'b1, 1'b0);
      wait_state(ST_HW_STANDBY);
      pins(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      cmp_state(ST_HW_STANDBY);
      pins(1'b0, 1'b1);
      wait_state(ST_RESET);
      cmp_data({31'h0, cpu_halt}, 32'h1);
      pins(1'b1, 1'b1);
      wait_state(ST_EXEC);
      wait_ctrl(7'h40, 7'h20);
      bus(1'b0, `STOP_LOW_ADDR, 32'h0);
      cmp_data(rd, 32'hFF);
      bus(1'b0, `MODE_CTRL_ADDR, 32'h0);
      cmp_data(rd, 32'h0);
      finish_test();
   end
endmodule
